// file: sssc_pkg.sv
// Constants and types for the short-stroke angle scaler
// Overview of operation
// [RQ1] Copy nonvolatile words into working fields at init
// [RQ2] Subtract 12-bit zero reference before gain
// [RQ3] Offset subtraction runs regardless of short-stroke enable
// [RQ4] Gain applied is one plus programmed field
// [RQ5] Gain field is unsigned 4.8 fixed point
// [RQ6] Software keeps total gain at most sixteen
// [RQ7] Above max angle: set flag, use ceiling
// [RQ8] Max angle zero disables max check
// [RQ9] Below min angle: set flag, use floor
// [RQ10] Min angle zero disables min check
// [RQ11] Range checks and clamping need short-stroke enable
// [RQ12] Final output limited between floor and ceiling
// [RQ13] Clamp limits are in angle resolution units
// [RQ14] Software disables clamping with 4096 and zero; the ceiling field here is 12 bits, so all-ones fff is used instead
// [RQ15] Term count above 8 reuses offset/gain word
// [RQ16] Term count above 9 reuses input-limit word
// [RQ17] Term count above 10 reuses clamp word
// [RQ18] Offset subtraction wraps modulo 4096
package sssc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [9:0] ADDR_ZERO_GAIN = 10'h314;
  localparam logic [9:0] ADDR_IN_LIMITS = 10'h315;
  localparam logic [9:0] ADDR_CLAMP     = 10'h316;
  localparam logic [9:0] ADDR_CTRL      = 10'h320;
  localparam logic [9:0] ADDR_STATUS    = 10'h321;
  localparam logic [9:0] ADDR_IRQ_MASK  = 10'h322;
  localparam logic [9:0] ADDR_ANGLE_OUT = 10'h323;
  localparam logic [9:0] ADDR_HARM_15   = 10'h324;
  localparam logic [9:0] ADDR_HARM_16   = 10'h325;
  localparam logic [9:0] ADDR_HARM_17   = 10'h326;

  localparam int WORD_W  = 24;
  localparam int ANGLE_W = 12;
  localparam int HI_LSB  = 12;
  localparam int ADV_LSB = 10;
  localparam int AMP_W   = 10;
  localparam int FRAC_W  = 8;
  localparam int PROD_W  = 25;

  // Control word fields
  localparam int CTRL_SS_BIT   = 0;
  localparam int CTRL_INIT_BIT = 1;
  localparam int CTRL_HAR_LSB  = 4;
  localparam int HAR_W         = 4;

  // Status bits
  localparam int ST_ABOVE = 0;
  localparam int ST_BELOW = 1;
  localparam int ST_W     = 2;

  // Harmonic reuse thresholds
  localparam logic [3:0] HAR_REUSE_GAIN  = 4'h8;
  localparam logic [3:0] HAR_REUSE_LIMIT = 4'h9;
  localparam logic [3:0] HAR_REUSE_CLAMP = 4'ha;

  localparam logic [23:0] RST_ZERO_GAIN = 24'h000000;
  localparam logic [23:0] RST_IN_LIMITS = 24'h000000;
  localparam logic [23:0] RST_CLAMP     = 24'hfff000;
  localparam logic [11:0] ANGLE_MAX     = 12'hfff;
  localparam logic [11:0] GAIN_ONE      = 12'h100;

  typedef enum logic [1:0] {SSSC_IDLE, SSSC_LOAD, SSSC_RUN} sssc_state_t;
endpackage : sssc_pkg

// file: sssc_scaler.sv
// Combinational angle datapath: offset, range check, gain, clamp
`timescale 1ns/1ps
`default_nettype none
module sssc_scaler (
  // Angle in
  input  wire logic [11:0] angle_in,
  input  wire logic        ss_enable,
  // Working fields
  input  wire logic [11:0] zero_ref,
  input  wire logic [11:0] gain,
  input  wire logic [11:0] upper_bound,
  input  wire logic [11:0] lower_bound,
  input  wire logic [11:0] ceiling,
  input  wire logic [11:0] floor_lim,
  // Result
  output      logic [11:0] angle_out,
  output      logic        above,
  output      logic        below
);
  // Wrapping subtraction keeps a full-turn offset legal
  wire logic [11:0] shifted = 12'(angle_in - zero_ref); // [RQ2] [RQ3] [RQ18]
  wire logic        hi_hit  = ss_enable && (upper_bound != 12'h000)
                              && (shifted > upper_bound); // [RQ7] [RQ8] [RQ11]
  wire logic        lo_hit  = ss_enable && (lower_bound != 12'h000)
                              && (shifted < lower_bound); // [RQ9] [RQ10] [RQ11]
  // Gain is 4.8 unsigned, plus one
  wire logic [12:0] gain_tot = {1'b0, gain} + {1'b0, sssc_pkg::GAIN_ONE}; // [RQ4] [RQ5]
  wire logic [24:0] product  = 25'({13'h0000, shifted} * {12'h000, gain_tot});
  wire logic [16:0] scaled   = product[24:sssc_pkg::FRAC_W];
  // Saturate rather than wrap when gain overshoots a turn
  wire logic [11:0] sat      = (scaled > {5'h00, sssc_pkg::ANGLE_MAX})
                               ? sssc_pkg::ANGLE_MAX : scaled[11:0];
  wire logic [11:0] pre      = hi_hit ? ceiling : (lo_hit ? floor_lim : sat); // [RQ7] [RQ9]
  // Limits in resolution units; 12-bit ceiling cannot hold 4096, so all-ones acts open
  wire logic [11:0] clamped  = (pre > ceiling) ? ceiling
                               : ((pre < floor_lim) ? floor_lim : pre); // [RQ12] [RQ13]

  assign angle_out = ss_enable ? clamped : sat; // [RQ11]
  assign above     = hi_hit;
  assign below     = lo_hit;
endmodule // sssc_scaler
`default_nettype wire

// file: sssc_top.sv
// Short-stroke angle scaler top: registers, init copy, harmonic reuse
`timescale 1ns/1ps
`default_nettype none
module sssc_top (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic [9:0]  REG_ADDR,
  input  wire logic [23:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output      logic [23:0] REG_RDATA,
  // Angle path
  input  wire logic [11:0] ANGLE_IN,
  input  wire logic        ANGLE_VALID,
  output      logic [11:0] ANGLE_OUT,
  output      logic        ANGLE_OUT_VALID,
  // Flags and interrupt
  output      logic        ABOVE_RANGE_FLAG,
  output      logic        BELOW_RANGE_FLAG,
  output      logic        IRQ,
  output      logic        HARM_LOAD_STROBE,
  output      logic        INIT_DONE
);
  // ****************************************
  // Nonvolatile words and control
  // ****************************************
  logic [23:0] nv_zero_gain_r;
  logic [23:0] nv_in_limits_r;
  logic [23:0] nv_clamp_r;
  logic [7:0]  ctrl_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;

  // Working copies used by the datapath, and harmonic entries filled from reused words
  logic [11:0] working_zero_reference_r;
  logic [11:0] working_gain_r;
  logic [11:0] working_upper_bound_r;
  logic [11:0] working_lower_bound_r;
  logic [11:0] working_output_ceiling_r;
  logic [11:0] working_output_floor_r;
  logic [23:0] harm_entry_15_r;
  logic [23:0] harm_entry_16_r;
  logic [23:0] harm_entry_17_r;

  sssc_pkg::sssc_state_t state_r;
  sssc_pkg::sssc_state_t state_nxt;

  logic [11:0] angle_out_r;
  logic        out_valid_r;
  logic        above_r;
  logic        below_r;
  logic        irq_r;
  logic        harm_strobe_r;
  logic [23:0] rdata_r;
  logic        init_done_r;

  // ****************************************
  // Decode
  // ****************************************
  wire logic       wr_zg    = REG_WR && (REG_ADDR == sssc_pkg::ADDR_ZERO_GAIN);
  wire logic       wr_il    = REG_WR && (REG_ADDR == sssc_pkg::ADDR_IN_LIMITS);
  wire logic       wr_cl    = REG_WR && (REG_ADDR == sssc_pkg::ADDR_CLAMP);
  wire logic       wr_ctrl  = REG_WR && (REG_ADDR == sssc_pkg::ADDR_CTRL);
  wire logic       wr_stat  = REG_WR && (REG_ADDR == sssc_pkg::ADDR_STATUS);
  wire logic       wr_mask  = REG_WR && (REG_ADDR == sssc_pkg::ADDR_IRQ_MASK);
  wire logic       init_req = wr_ctrl && REG_WDATA[sssc_pkg::CTRL_INIT_BIT];
  wire logic       ss_en    = ctrl_r[sssc_pkg::CTRL_SS_BIT];
  wire logic [3:0] harmonic_term_count =
    ctrl_r[sssc_pkg::CTRL_HAR_LSB +: sssc_pkg::HAR_W];
  wire logic reuse_gain  = harmonic_term_count > sssc_pkg::HAR_REUSE_GAIN;  // [RQ15]
  wire logic reuse_limit = harmonic_term_count > sssc_pkg::HAR_REUSE_LIMIT; // [RQ16]
  wire logic reuse_clamp = harmonic_term_count > sssc_pkg::HAR_REUSE_CLAMP; // [RQ17]
  wire logic load_now    = (state_r == sssc_pkg::SSSC_LOAD);

  // ****************************************
  // Datapath
  // ****************************************
  wire logic [11:0] dp_angle;
  wire logic        dp_above;
  wire logic        dp_below;

  sssc_scaler u_scaler (
    .angle_in    (ANGLE_IN),
    .ss_enable   (ss_en),
    .zero_ref    (working_zero_reference_r),
    .gain        (working_gain_r),
    .upper_bound (working_upper_bound_r),
    .lower_bound (working_lower_bound_r),
    .ceiling     (working_output_ceiling_r),
    .floor_lim   (working_output_floor_r),
    .angle_out   (dp_angle),
    .above       (dp_above),
    .below       (dp_below)
  );

  wire logic run_sample = ANGLE_VALID && (state_r == sssc_pkg::SSSC_RUN);
  wire logic ev_above   = run_sample && dp_above;
  wire logic ev_below   = run_sample && dp_below;
  wire logic [1:0] ev_vec   = {ev_below, ev_above};
  wire logic [1:0] clr_vec  = wr_stat ? REG_WDATA[1:0] : 2'h0;
  // Set beats a simultaneous write-one clear
  wire logic [1:0] status_nxt = (status_r & ~clr_vec) | ev_vec;
  wire logic [1:0] mask_nxt   = wr_mask ? REG_WDATA[1:0] : mask_r;

  // ****************************************
  // Read mux
  // ****************************************
  wire logic [23:0] rd_mux =
    (REG_ADDR == sssc_pkg::ADDR_ZERO_GAIN) ? nv_zero_gain_r :
    (REG_ADDR == sssc_pkg::ADDR_IN_LIMITS) ? nv_in_limits_r :
    (REG_ADDR == sssc_pkg::ADDR_CLAMP)     ? nv_clamp_r :
    (REG_ADDR == sssc_pkg::ADDR_CTRL)      ? {16'h0000, ctrl_r} :
    (REG_ADDR == sssc_pkg::ADDR_STATUS)    ? {22'h000000, status_r} :
    (REG_ADDR == sssc_pkg::ADDR_IRQ_MASK)  ? {22'h000000, mask_r} :
    (REG_ADDR == sssc_pkg::ADDR_ANGLE_OUT) ? {12'h000, angle_out_r} :
    (REG_ADDR == sssc_pkg::ADDR_HARM_15)   ? harm_entry_15_r :
    (REG_ADDR == sssc_pkg::ADDR_HARM_16)   ? harm_entry_16_r :
    (REG_ADDR == sssc_pkg::ADDR_HARM_17)   ? harm_entry_17_r : 24'h000000;

  // ****************************************
  // Init sequencer
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      sssc_pkg::SSSC_IDLE: if (init_req) state_nxt = sssc_pkg::SSSC_LOAD;
      sssc_pkg::SSSC_LOAD: state_nxt = sssc_pkg::SSSC_RUN;
      sssc_pkg::SSSC_RUN:  if (init_req) state_nxt = sssc_pkg::SSSC_LOAD;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state_r        <= sssc_pkg::SSSC_IDLE;
      init_done_r    <= 1'b0;
      nv_zero_gain_r <= sssc_pkg::RST_ZERO_GAIN;
      nv_in_limits_r <= sssc_pkg::RST_IN_LIMITS;
      nv_clamp_r     <= sssc_pkg::RST_CLAMP;
      ctrl_r         <= 8'h00;
      status_r       <= 2'h0;
      mask_r         <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      // Registered so the ready flag leaves the block glitch free
      init_done_r <= (state_nxt == sssc_pkg::SSSC_RUN);
      if (wr_zg) nv_zero_gain_r <= REG_WDATA;
      if (wr_il) nv_in_limits_r <= REG_WDATA;
      if (wr_cl) nv_clamp_r <= REG_WDATA;
      if (wr_ctrl) ctrl_r <= {REG_WDATA[7:2], 1'b0, REG_WDATA[0]};
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  // Working fields change only at init; words being rewritten do not disturb the path
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      working_zero_reference_r <= 12'h000;
      working_gain_r           <= 12'h000;
      working_upper_bound_r    <= 12'h000;
      working_lower_bound_r    <= 12'h000;
      working_output_ceiling_r <= sssc_pkg::ANGLE_MAX;
      working_output_floor_r   <= 12'h000;
      harm_entry_15_r          <= 24'h000000;
      harm_entry_16_r          <= 24'h000000;
      harm_entry_17_r          <= 24'h000000;
    end
    else if (load_now)
    begin
      // [RQ1]
      if (reuse_gain)
      begin
        harm_entry_17_r          <= nv_zero_gain_r; // [RQ15]
        working_zero_reference_r <= 12'h000;
        working_gain_r           <= 12'h000;
      end
      else
      begin
        working_zero_reference_r <= nv_zero_gain_r[23:12]; // [RQ1]
        working_gain_r           <= nv_zero_gain_r[11:0];
      end
      if (reuse_limit)
      begin
        harm_entry_15_r       <= nv_in_limits_r; // [RQ16]
        working_upper_bound_r <= 12'h000;
        working_lower_bound_r <= 12'h000;
      end
      else
      begin
        working_upper_bound_r <= nv_in_limits_r[23:12];
        working_lower_bound_r <= nv_in_limits_r[11:0];
      end
      if (reuse_clamp)
      begin
        harm_entry_16_r          <= nv_clamp_r; // [RQ17]
        working_output_ceiling_r <= sssc_pkg::ANGLE_MAX;
        working_output_floor_r   <= 12'h000;
      end
      else
      begin
        working_output_ceiling_r <= nv_clamp_r[23:12];
        working_output_floor_r   <= nv_clamp_r[11:0];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      angle_out_r   <= 12'h000;
      out_valid_r   <= 1'b0;
      above_r       <= 1'b0;
      below_r       <= 1'b0;
      irq_r         <= 1'b0;
      harm_strobe_r <= 1'b0;
      rdata_r       <= 24'h000000;
    end
    else
    begin
      if (run_sample) angle_out_r <= dp_angle;
      out_valid_r   <= run_sample;
      above_r       <= status_nxt[sssc_pkg::ST_ABOVE];
      below_r       <= status_nxt[sssc_pkg::ST_BELOW];
      irq_r         <= |(status_nxt & mask_nxt);
      harm_strobe_r <= load_now && (reuse_gain || reuse_limit || reuse_clamp);
      rdata_r       <= REG_RD ? rd_mux : 24'h000000;
    end
  end

  assign REG_RDATA        = rdata_r;
  assign ANGLE_OUT        = angle_out_r;
  assign ANGLE_OUT_VALID  = out_valid_r;
  assign ABOVE_RANGE_FLAG = above_r;
  assign BELOW_RANGE_FLAG = below_r;
  assign IRQ              = irq_r;
  assign HARM_LOAD_STROBE = harm_strobe_r;
  assign INIT_DONE        = init_done_r;
endmodule // sssc_top
`default_nettype wire

// file: sssc_chk_sva.sv
// Concurrent checks on the scaler top ports
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module sssc_chk (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST,
  // Register port
  input wire logic [9:0]  REG_ADDR,
  input wire logic [23:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [23:0] REG_RDATA,
  // Angle path and flags
  input wire logic        ANGLE_VALID,
  input wire logic [11:0] ANGLE_OUT,
  input wire logic        ANGLE_OUT_VALID,
  input wire logic        ABOVE_RANGE_FLAG,
  input wire logic        BELOW_RANGE_FLAG,
  input wire logic        HARM_LOAD_STROBE,
  input wire logic        INIT_DONE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  chk_take_sample: assert property (ANGLE_VALID && INIT_DONE |=> ANGLE_OUT_VALID)
    else $error("sample not answered");
  chk_drop_early: assert property (ANGLE_VALID && !INIT_DONE |=> !ANGLE_OUT_VALID)
    else $error("sample taken before init");
  // Output only moves with a fresh sample
  chk_out_hold: assert property (!ANGLE_OUT_VALID |-> $stable(ANGLE_OUT))
    else $error("angle moved without sample");
  chk_read_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 24'h0)
    else $error("read data outside read slot");
  chk_init_two: assert property (REG_WR && REG_ADDR == sssc_pkg::ADDR_CTRL && REG_WDATA[1]
    |=> !INIT_DONE ##1 INIT_DONE)
    else $error("init copy latency wrong");
  chk_harm_init: assert property (HARM_LOAD_STROBE |-> $rose(INIT_DONE))
    else $error("harmonic load outside init");
  // Flags rise on the same edge as the answered sample
  chk_above_src: assert property ($rose(ABOVE_RANGE_FLAG) |-> ANGLE_OUT_VALID)
    else $error("above flag without sample");
  chk_below_src: assert property ($rose(BELOW_RANGE_FLAG) |-> ANGLE_OUT_VALID)
    else $error("below flag without sample");
endmodule // sssc_chk

bind sssc_top sssc_chk u_chk (.CORE_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
  .REG_RDATA, .ANGLE_VALID, .ANGLE_OUT, .ANGLE_OUT_VALID, .ABOVE_RANGE_FLAG,
  .BELOW_RANGE_FLAG, .HARM_LOAD_STROBE, .INIT_DONE);
`default_nettype wire

// file: tb_short_stroke_angle_scaler.sv
// Self-checking bench for the scaler top
`timescale 1ns/1ps
`default_nettype none
module tb_short_stroke_angle_scaler;
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  logic [9:0]  REG_ADDR = 10'h0;
  logic [23:0] REG_WDATA = 24'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [11:0] ANGLE_IN = 12'h0;
  logic        ANGLE_VALID = 1'b0;
  logic [23:0] REG_RDATA;
  logic [11:0] ANGLE_OUT;
  logic        ANGLE_OUT_VALID, ABOVE_RANGE_FLAG, BELOW_RANGE_FLAG, IRQ, HARM_LOAD_STROBE;
  logic        INIT_DONE;
  int          bad_count = 0;
  int          num_checks = 0;
  // Model copy of the working fields
  int          zr, g, up, lo, ce, fl, ss, st;

  sssc_top uut (.CORE_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .ANGLE_IN, .ANGLE_VALID, .ANGLE_OUT, .ANGLE_OUT_VALID, .ABOVE_RANGE_FLAG,
    .BELOW_RANGE_FLAG, .IRQ, .HARM_LOAD_STROBE, .INIT_DONE);

  initial
  begin
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] v);
    num_checks++;
    if (v !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [23:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [23:0] e);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(negedge CORE_CLK);
    cmp($sformatf("reg %h", a), e, REG_RDATA);
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(negedge CORE_CLK);
    cmp("irq", {23'h0, v}, {23'h0, IRQ});
  endtask

  // Reused words fall back to neutral working fields
  task automatic cfg(input logic [23:0] zg, lim, clp, input logic [3:0] h, input logic s);
    wr(sssc_pkg::ADDR_ZERO_GAIN, zg);
    wr(sssc_pkg::ADDR_IN_LIMITS, lim);
    wr(sssc_pkg::ADDR_CLAMP, clp);
    wr(sssc_pkg::ADDR_CTRL, {16'h0, h, 2'b00, 1'b1, s});
    @(posedge CORE_CLK);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge CORE_CLK);
      if (INIT_DONE === 1'b1)
        break;
    end
    if (INIT_DONE !== 1'b1)
    begin
      bad_count++;
      wrap_up;
    end
    cmp("harm strobe", {23'h0, h > 8}, {23'h0, HARM_LOAD_STROBE});
    zr = h > 8 ? 0 : zg[23:12];
    g = h > 8 ? 0 : zg[11:0];
    up = h > 9 ? 0 : lim[23:12];
    lo = h > 9 ? 0 : lim[11:0];
    ce = h > 10 ? 'hfff : clp[23:12];
    fl = h > 10 ? 0 : clp[11:0];
    ss = s;
    if (h > 8)
      rd(sssc_pkg::ADDR_HARM_17, zg);
    if (h > 9)
      rd(sssc_pkg::ADDR_HARM_15, lim);
    if (h > 10)
      rd(sssc_pkg::ADDR_HARM_16, clp);
  endtask

  task automatic smp(input int a, input logic v);
    int s;
    int e;
    logic ab;
    logic bl;
    s = (a - zr) & 'hfff;
    ab = ss && up != 0 && s > up;
    bl = ss && lo != 0 && s < lo;
    e = (s * (g + 256)) >> 8;
    e = e > 4095 ? 4095 : e;
    e = ab ? ce : bl ? fl : e;
    if (ss)
      e = e > ce ? ce : e < fl ? fl : e;
    st = st | {bl, ab};
    @(posedge CORE_CLK);
    ANGLE_IN <= 12'(a);
    ANGLE_VALID <= 1'b1;
    @(posedge CORE_CLK);
    ANGLE_VALID <= 1'b0;
    @(negedge CORE_CLK);
    cmp("out valid", {23'h0, v}, {23'h0, ANGLE_OUT_VALID});
    if (v)
      cmp("angle", 24'(e), {12'h0, ANGLE_OUT});
    @(negedge CORE_CLK);
    cmp("flags", 24'(st), {22'h0, BELOW_RANGE_FLAG, ABOVE_RANGE_FLAG});
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge CORE_CLK);
    RST <= 1'b0;
    rd(sssc_pkg::ADDR_ZERO_GAIN, 24'h0);
    rd(sssc_pkg::ADDR_IN_LIMITS, 24'h0);
    rd(sssc_pkg::ADDR_CLAMP, 24'hfff000);
    rd(10'h3ff, 24'h0);
    smp(12'h123, 1'b0);
    // Gain kept at two, well inside the recommended sixteen
    cfg(24'h100100, 24'h200080, 24'h300020, 4'h0, 1'b0);
    smp(12'h050, 1'b1);
    smp(12'h180, 1'b1);
    cfg(24'h100100, 24'h200080, 24'h300020, 4'h0, 1'b1);
    smp(12'h150, 1'b1);
    smp(12'h380, 1'b1);
    smp(12'h1c0, 1'b1);
    smp(12'h2f0, 1'b1);
    // Rewritten word without init must not reach the path
    wr(sssc_pkg::ADDR_ZERO_GAIN, 24'h000000);
    smp(12'h1c0, 1'b1);
    rd(sssc_pkg::ADDR_STATUS, 24'h3);
    irq_is(1'b0);
    wr(sssc_pkg::ADDR_IRQ_MASK, 24'h1);
    irq_is(1'b1);
    wr(sssc_pkg::ADDR_STATUS, 24'h1);
    irq_is(1'b0);
    rd(sssc_pkg::ADDR_STATUS, 24'h2);
    wr(sssc_pkg::ADDR_IRQ_MASK, 24'h2);
    irq_is(1'b1);
    wr(sssc_pkg::ADDR_STATUS, 24'h2);
    irq_is(1'b0);
    st = 0;
    // All-ones ceiling is the nearest 12-bit form of an open clamp
    cfg(24'h000000, 24'h000000, 24'hfff000, 4'h0, 1'b1);
    smp(12'hffe, 1'b1);
    smp(12'h001, 1'b1);
    wr(sssc_pkg::ADDR_ANGLE_OUT, 24'h000555);
    rd(sssc_pkg::ADDR_ANGLE_OUT, 24'h000001);
    for (int h = 8; h < 12; h++)
    begin
      cfg(24'h400100, 24'h800100, 24'h700200, 4'(h), 1'b1);
      smp(12'ha00, 1'b1);
    end
    wrap_up;
  end
endmodule // tb_short_stroke_angle_scaler
`default_nettype wire
